// file: rtl/emb_consts.svh
// constants for the external memory bus control block
// included by the package, the block buffer and the bus control files
`ifndef EMB_CONSTS_SVH
`define EMB_CONSTS_SVH
// register indices on the plain register port
`define EMB_OFS_PTR_UPPER 3'h0
`define EMB_OFS_PTR_HIGH 3'h1
`define EMB_OFS_PTR_LOW 3'h2
`define EMB_OFS_LATCH 3'h3
`define EMB_OFS_CONTROL 3'h4
// memory control field positions
`define EMB_CTL_DIS_BIT 7
`define EMB_CTL_WAIT_HI 5
`define EMB_CTL_WAIT_LO 4
`define EMB_CTL_WM_HI 1
`define EMB_CTL_WM_LO 0
`define EMB_CTL_IMPL_MASK 8'hB3
`define EMB_CTL_RESET 8'h00
`define EMB_PTR_RESET 22'h000000
`define EMB_LATCH_RESET 8'h00
// timing counts in ref_clk cycles
`define EMB_TCY_CLKS 6'h04
`define EMB_STROBE_CLKS 6'h02
// on-chip memory map
`define EMB_INT_TOP 21'h010000
`define EMB_BLOCK_LAST 6'h3F
`define EMB_WORDS_PER_BLOCK 5'h1F
`endif

// file: rtl/emb_pkg.sv
// types shared by the external memory bus control files
// assumes emb_consts.svh sits beside it
`include "emb_consts.svh"
package emb_pkg;
  // pointer update applied by a table operation
  typedef enum logic [1:0] {
    EMB_PTR_KEEP = 2'b00,
    EMB_PTR_POSTINC = 2'b01,
    EMB_PTR_POSTDEC = 2'b10,
    EMB_PTR_PREINC = 2'b11
  } emb_ptrop_t;
  // table operation sequencer
  typedef enum logic [2:0] {
    EMB_IDLE = 3'b000,
    EMB_ADDR = 3'b001,
    EMB_LATCH = 3'b010,
    EMB_STROBE = 3'b011,
    EMB_INTRD = 3'b100,
    EMB_FINISH = 3'b101
  } emb_state_t;
endpackage : emb_pkg

// file: rtl/emb_sync.sv
// two flip-flop synchroniser for pin levels
// assumes inputs are asynchronous to ref_clk
`timescale 1ns/1ps
module emb_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // level in and synchronised level out
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_reg;

  // first stage feeds only the second
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1_reg <= '0;
      syncOut <= '0;
    end else begin
      stage1_reg <= asyncIn;
      syncOut <= stage1_reg;
    end
  end
endmodule : emb_sync

// file: rtl/emb_block_buffer.sv
// 64-byte on-chip write block buffer with word streaming on commit
// assumes the caller holds off writes while busy is high
`timescale 1ns/1ps
`include "emb_consts.svh"
module emb_block_buffer (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // byte fill side
  input wire logic byteWrite,
  input wire logic [5:0] byteIndex,
  input wire logic [7:0] byteData,
  input wire logic commit,
  input wire logic [15:0] blockBase,
  // on-chip array write side
  output logic flashWrite,
  output logic [21:0] flashWrAddr,
  output logic [15:0] flashWrData,
  output logic busy
);
  logic [7:0] block_reg [64];
  logic [4:0] wordIdx_reg;
  logic [15:0] base_reg;

  // byte store, index aligned inside the block
  always_ff @(posedge ref_clk) begin
    if (byteWrite) begin
      block_reg[byteIndex] <= byteData;
    end
  end

  // stream 32 words once the block is committed
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy <= 1'b0;
      wordIdx_reg <= 5'h00;
      base_reg <= 16'h0000;
      flashWrite <= 1'b0;
      flashWrAddr <= 22'h000000;
      flashWrData <= 16'h0000;
    end else begin
      flashWrite <= busy;
      if (busy) begin
        flashWrAddr <= {base_reg, wordIdx_reg, 1'b0};
        flashWrData <= {block_reg[{wordIdx_reg, 1'b1}],
                        block_reg[{wordIdx_reg, 1'b0}]};
        wordIdx_reg <= wordIdx_reg + 5'h01;
        if (wordIdx_reg == `EMB_WORDS_PER_BLOCK) begin
          busy <= 1'b0;
        end
      end else if (commit) begin
        busy <= 1'b1;
        base_reg <= blockBase;
        wordIdx_reg <= 5'h00;
      end
    end
  end
endmodule : emb_block_buffer

// file: rtl/emb_bus_control.sv
// external memory bus control: table pointer, latch, memory control
// and the table read/write bus sequencer driving the shared pins
// assumes a CPU issues table operations and a port block uses
// pinsToBus to select between bus and I/O functions
//
// What this block does
// - twenty address/data lines and eight control lines form the bus
// - sixteen-bit and multiplexed eight-bit data widths only
// - width taken from a fuse, never from software
// - disable bit 0 gives pins to bus, 1 returns them to I/O except during external execution or an external cycle
// - wait code 11,10,01,00 adds 0,1,2,3 instruction cycles
// - word mode outputs both latch bytes, high strobe on odd byte
// - byte select copies byte, high strobe with upper or lower enable
// - byte write copies byte, high or low strobe by address
// - upper pointer holds bits 21..16, top two bits read zero
// - high and low pointer bytes are read/write
// - read/write latch holds each transferred byte
// - on-chip memory written only in serial programming mode
// - serial mode writes program 64-byte blocks at once
// - write blocks aligned like code protection blocks
// - serial mode commands erase code blocks or whole device
// - internal execution idles bus: lines released, strobes high
// - pointer kept, post-inc, post-dec or pre-inc on low 21 bits
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "emb_consts.svh"
module emb_bus_control (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // register port
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  // table operation request from the CPU
  input wire logic opStart,
  input wire logic opIsWrite,
  input wire emb_pkg::emb_ptrop_t opPtrMode,
  output logic opDone,
  output logic opBusy,
  // device state
  input wire logic execExternal,
  input wire logic serialProgrammingMode,
  input wire logic busWidthFuse,
  // erase commands
  input wire logic eraseStart,
  input wire logic eraseWholeDevice,
  output logic flashErase,
  output logic flashEraseAll,
  output logic [21:0] flashEraseAddr,
  // on-chip array
  output logic flashRead,
  output logic [21:0] flashRdAddr,
  input wire logic [15:0] flashRdData,
  output logic flashWrite,
  output logic [21:0] flashWrAddr,
  output logic [15:0] flashWrData,
  // address/data pins
  input wire logic [19:0] adIn,
  output logic [19:0] adOut,
  output logic [19:0] adOe_n,
  // control pins, all driven while bus owns them
  output logic addrLatchStrobe,
  output logic outputEnable_n,
  output logic write_low_strobe_n,
  output logic write_high_strobe_n,
  output logic byte_address_lsb,
  output logic chipEnable_n,
  output logic lower_byte_enable_n,
  output logic upper_byte_enable_n,
  output logic ctlOe_n,
  output logic pinsToBus
);
  import emb_pkg::*;

  emb_state_t state_reg;
  logic [21:0] table_pointer_reg;
  logic [21:0] opAddr_reg;
  logic [7:0] table_latch_reg;
  logic [7:0] latch_even_byte_reg;
  logic [7:0] memory_control_reg;
  logic opWrite_reg;
  emb_ptrop_t opMode_reg;
  logic [5:0] count_reg;
  logic [5:0] countStart;
  logic [7:0] rdByte_reg;
  logic wideBus_reg;
  logic fuseTaken_reg;
  logic [19:0] adSync;
  logic [15:0] wrWord_reg;
  logic serialSync;
  logic external_bus_disable;
  logic [1:0] write_mode_select;
  logic [1:0] waitCode;
  logic [20:0] ptrLow;
  logic [21:0] startAddr;
  logic startInternal;
  logic evenOnly;
  logic bufWrite;
  logic bufCommit;
  logic bufBusy;
  logic regRdHit;

  // pin inputs pass two flip-flops first
  emb_sync #(.WIDTH(21)) u_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .asyncIn({serialProgrammingMode, adIn}),
    .syncOut({serialSync, adSync})
  );

  // memory control fields
  assign external_bus_disable = memory_control_reg[`EMB_CTL_DIS_BIT];
  assign waitCode =
    memory_control_reg[`EMB_CTL_WAIT_HI:`EMB_CTL_WAIT_LO];
  assign write_mode_select =
    memory_control_reg[`EMB_CTL_WM_HI:`EMB_CTL_WM_LO];

  // bus width strap caught once after reset release
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      fuseTaken_reg <= 1'b0;
      wideBus_reg <= 1'b0;
    end else if (!fuseTaken_reg) begin
      fuseTaken_reg <= 1'b1;
      wideBus_reg <= busWidthFuse;
    end
  end

  // memory control register, implemented bits only
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      memory_control_reg <= `EMB_CTL_RESET;
    end else if (regWrite && regAddr == `EMB_OFS_CONTROL) begin
      memory_control_reg <= regWrData & `EMB_CTL_IMPL_MASK;
    end
  end

  // start address: pre-increment touches the low 21 bits only
  assign ptrLow = table_pointer_reg[20:0];
  always_comb begin
    startAddr = table_pointer_reg;
    if (opPtrMode == EMB_PTR_PREINC) begin
      startAddr = {table_pointer_reg[21], ptrLow + 21'h000001};
    end
  end
  assign startInternal =
    !startAddr[21] && (startAddr[20:0] < `EMB_INT_TOP);
  // word mode even byte only parks the byte for the odd write
  assign evenOnly = wideBus_reg && write_mode_select[1] &&
                    !startAddr[0];

  // wait count: code inverted gives added instruction cycles
  always_comb begin
    countStart = `EMB_STROBE_CLKS - 6'h01;
    case (waitCode)
      2'b11: countStart = `EMB_STROBE_CLKS - 6'h01;
      2'b10: countStart = `EMB_STROBE_CLKS + `EMB_TCY_CLKS - 6'h01;
      2'b01: countStart = `EMB_STROBE_CLKS + 6'h07;
      2'b00: countStart = `EMB_STROBE_CLKS + 6'h0B;
      default: countStart = `EMB_STROBE_CLKS - 6'h01;
    endcase
  end

  // on-chip block fill, refused outside serial programming mode
  assign bufWrite = (state_reg == EMB_IDLE) && opStart && opIsWrite &&
                    startInternal && serialSync && !bufBusy;
  assign bufCommit = bufWrite &&
                     (startAddr[5:0] == `EMB_BLOCK_LAST);

  emb_block_buffer u_block (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .byteWrite(bufWrite),
    .byteIndex(startAddr[5:0]),
    .byteData(table_latch_reg),
    .commit(bufCommit),
    .blockBase(startAddr[21:6]),
    .flashWrite(flashWrite),
    .flashWrAddr(flashWrAddr),
    .flashWrData(flashWrData),
    .busy(bufBusy)
  );

  // table operation sequencer
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= EMB_IDLE;
      opAddr_reg <= `EMB_PTR_RESET;
      opWrite_reg <= 1'b0;
      opMode_reg <= EMB_PTR_KEEP;
      count_reg <= 6'h00;
    end else begin
      case (state_reg)
        EMB_IDLE: begin
          if (opStart && !(opIsWrite && startInternal && bufBusy)) begin
            opAddr_reg <= startAddr;
            opWrite_reg <= opIsWrite;
            opMode_reg <= opPtrMode;
            if (startInternal) begin
              state_reg <= opIsWrite ? EMB_FINISH : EMB_INTRD;
            end else if (opIsWrite && evenOnly) begin
              state_reg <= EMB_FINISH;
            end else begin
              state_reg <= EMB_ADDR;
            end
          end
        end
        EMB_ADDR: begin
          state_reg <= EMB_LATCH;
        end
        EMB_LATCH: begin
          count_reg <= countStart;
          state_reg <= EMB_STROBE;
        end
        EMB_STROBE: begin
          if (count_reg == 6'h00) begin
            state_reg <= EMB_FINISH;
          end else begin
            count_reg <= count_reg - 6'h01;
          end
        end
        EMB_INTRD: begin
          state_reg <= EMB_FINISH;
        end
        EMB_FINISH: begin
          state_reg <= EMB_IDLE;
        end
        default: begin
          state_reg <= EMB_IDLE;
        end
      endcase
    end
  end

  // read byte capture from the on-chip array
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdByte_reg <= 8'h00;
    end else if (state_reg == EMB_INTRD) begin
      rdByte_reg <= opAddr_reg[0] ? flashRdData[15:8] : flashRdData[7:0];
    end
  end

  // write data word chosen by width and write mode
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wrWord_reg <= 16'h0000;
      latch_even_byte_reg <= 8'h00;
    end else if (state_reg == EMB_IDLE && opStart && opIsWrite) begin
      if (evenOnly) begin
        latch_even_byte_reg <= table_latch_reg;
      end
      if (wideBus_reg && write_mode_select[1]) begin
        wrWord_reg <= {table_latch_reg, latch_even_byte_reg};
      end else begin
        wrWord_reg <= {table_latch_reg, table_latch_reg};
      end
    end
  end

  // table pointer: post update at finish wins over register writes
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      table_pointer_reg <= `EMB_PTR_RESET;
    end else if (state_reg == EMB_FINISH) begin
      case (opMode_reg)
        EMB_PTR_POSTINC: table_pointer_reg <=
          {opAddr_reg[21], opAddr_reg[20:0] + 21'h000001};
        EMB_PTR_POSTDEC: table_pointer_reg <=
          {opAddr_reg[21], opAddr_reg[20:0] - 21'h000001};
        default: table_pointer_reg <= opAddr_reg;
      endcase
    end else if (regWrite) begin
      case (regAddr)
        `EMB_OFS_PTR_UPPER:
          table_pointer_reg[21:16] <= regWrData[5:0];
        `EMB_OFS_PTR_HIGH: table_pointer_reg[15:8] <= regWrData;
        `EMB_OFS_PTR_LOW: table_pointer_reg[7:0] <= regWrData;
        default: table_pointer_reg <= table_pointer_reg;
      endcase
    end
  end

  // table latch: loaded by reads, writable by software
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      table_latch_reg <= `EMB_LATCH_RESET;
    end else if (state_reg == EMB_FINISH && !opWrite_reg) begin
      if (opAddr_reg[21] || opAddr_reg[20:0] >= `EMB_INT_TOP) begin
        table_latch_reg <= (wideBus_reg && opAddr_reg[0]) ?
                           adSync[15:8] : adSync[7:0];
      end else begin
        table_latch_reg <= rdByte_reg;
      end
    end else if (regWrite && regAddr == `EMB_OFS_LATCH) begin
      table_latch_reg <= regWrData;
    end
  end

  // erase commands honoured only in serial programming mode
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      flashErase <= 1'b0;
      flashEraseAll <= 1'b0;
      flashEraseAddr <= 22'h000000;
    end else begin
      flashErase <= eraseStart && serialSync && !bufBusy;
      if (eraseStart) begin
        flashEraseAll <= eraseWholeDevice;
        flashEraseAddr <= table_pointer_reg;
      end
    end
  end

  // register read data, one cycle after the strobe
  assign regRdHit = regRead && (regAddr <= `EMB_OFS_CONTROL);
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      regRdData <= 8'h00;
    end else if (regRdHit) begin
      case (regAddr)
        `EMB_OFS_PTR_UPPER:
          regRdData <= {2'b00, table_pointer_reg[21:16]};
        `EMB_OFS_PTR_HIGH: regRdData <= table_pointer_reg[15:8];
        `EMB_OFS_PTR_LOW: regRdData <= table_pointer_reg[7:0];
        `EMB_OFS_LATCH: regRdData <= table_latch_reg;
        default: regRdData <= memory_control_reg;
      endcase
    end else begin
      regRdData <= 8'h00;
    end
  end

  // handshake and on-chip read request
  assign opDone = (state_reg == EMB_FINISH);
  assign opBusy = (state_reg != EMB_IDLE) || bufBusy;
  assign flashRead = (state_reg == EMB_INTRD);
  assign flashRdAddr = {opAddr_reg[21:1], 1'b0};

  // pin ownership: bus while enabled or while an external cycle runs
  assign pinsToBus = !external_bus_disable || execExternal ||
                     (state_reg == EMB_ADDR) ||
                     (state_reg == EMB_LATCH) ||
                     (state_reg == EMB_STROBE);
  assign ctlOe_n = !pinsToBus;

  // address phase then data phase on the shared lines
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      adOut <= 20'h00000;
    end else if (state_reg == EMB_IDLE) begin
      adOut <= wideBus_reg ? startAddr[20:1] : startAddr[19:0];
    end else if (state_reg == EMB_LATCH) begin
      adOut <= {4'h0, wrWord_reg};
    end
  end

  // line drive: address lines during address, data only on writes
  always_comb begin
    adOe_n = 20'hFFFFF;
    if (state_reg == EMB_ADDR || state_reg == EMB_LATCH) begin
      adOe_n = 20'h00000;
    end else if (state_reg == EMB_STROBE) begin
      adOe_n = 20'hFFFFF;
      if (opWrite_reg) begin
        adOe_n = wideBus_reg ? 20'hF0000 : 20'hFFF00;
      end
    end
  end

  // control strobes; idle levels hold the bus quiet
  always_comb begin
    addrLatchStrobe = (state_reg == EMB_ADDR);
    chipEnable_n = 1'b1;
    outputEnable_n = 1'b1;
    write_low_strobe_n = 1'b1;
    write_high_strobe_n = 1'b1;
    lower_byte_enable_n = 1'b1;
    upper_byte_enable_n = 1'b1;
    byte_address_lsb = 1'b0;
    if (state_reg == EMB_ADDR || state_reg == EMB_LATCH ||
        state_reg == EMB_STROBE) begin
      chipEnable_n = 1'b0;
      byte_address_lsb = wideBus_reg ? opAddr_reg[0] : 1'b0;
    end
    if (state_reg == EMB_STROBE && !opWrite_reg) begin
      outputEnable_n = 1'b0;
      lower_byte_enable_n = 1'b0;
      upper_byte_enable_n = 1'b0;
    end else if (state_reg == EMB_STROBE && !wideBus_reg) begin
      write_low_strobe_n = 1'b0;
    end else if (state_reg == EMB_STROBE) begin
      case (write_mode_select)
        2'b00: begin
          write_high_strobe_n = !opAddr_reg[0];
          write_low_strobe_n = opAddr_reg[0];
        end
        2'b01: begin
          write_high_strobe_n = 1'b0;
          upper_byte_enable_n = !opAddr_reg[0];
          lower_byte_enable_n = opAddr_reg[0];
        end
        default: begin
          write_high_strobe_n = 1'b0;
          upper_byte_enable_n = 1'b0;
          lower_byte_enable_n = 1'b0;
        end
      endcase
    end
  end
endmodule : emb_bus_control

// file: dv/emb_bus_control_checker.sv
// checker bound to emb_bus_control, watching its ports only
// assumes one clock domain and reset_n active low
`timescale 1ns/1ps
module emb_bus_control_checker (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // register port
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdData,
  // operations and modes
  input wire logic opDone,
  input wire logic opBusy,
  input wire logic execExternal,
  input wire logic serialProgrammingMode,
  input wire logic flashErase,
  input wire logic flashWrite,
  // pins
  input wire logic [19:0] adOe_n,
  input wire logic addrLatchStrobe,
  input wire logic write_low_strobe_n,
  input wire logic write_high_strobe_n,
  input wire logic pinsToBus
);
  logic [7:0] ctlReg;
  logic [5:0] waitCnt;
  logic [5:0] runCnt;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // shadow of the control byte as software wrote it
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) ctlReg <= 8'h00;
    else if (regWrite && regAddr == 3'h4) ctlReg <= regWrData;
  end
  // cycles since the address phase of an external cycle
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) waitCnt <= 6'h00;
    else if (addrLatchStrobe) waitCnt <= 6'h01;
    else if (opDone) waitCnt <= 6'h00;
    else if (waitCnt != 6'h00) waitCnt <= waitCnt + 6'h01;
  end
  // length of the current array write burst
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) runCnt <= 6'h00;
    else if (flashWrite) runCnt <= runCnt + 6'h01;
    else runCnt <= 6'h00;
  end
  sequence s_rdUpper;
    regRead && regAddr == 3'h0;
  endsequence
  sequence s_rdCtl;
    regRead && regAddr == 3'h4;
  endsequence
  a_upper_top_zero:
    assert property (s_rdUpper |=> regRdData[7:6] == 2'b00)
    else $error("upper bits set");
  a_ctl_readback:
    assert property (s_rdCtl |=> regRdData == (ctlReg & 8'hB3))
    else $error("readback");
  // finish 4 cycles after address phase, plus 4 per wait
  a_wait_stretch:
    assert property (opDone && waitCnt != 6'h00 |->
      waitCnt == 6'h10 - {2'b00, ctlReg[5:4], 2'b00})
    else $error("wait length");
  a_idle_released:
    assert property (!opBusy && !opDone && !execExternal |-> &adOe_n
      && write_low_strobe_n && write_high_strobe_n && !addrLatchStrobe)
    else $error("bus not idle");
  a_bus_enabled:
    assert property (!ctlReg[7] |-> pinsToBus)
    else $error("pins lost");
  a_bus_disabled:
    assert property (ctlReg[7] && !execExternal
      && !opBusy && !opDone |-> !pinsToBus)
    else $error("pins kept");
  a_array_guard:
    assert property (flashWrite || flashErase
      |-> $past(serialProgrammingMode, 4))
    else $error("array touched");
  a_block_length:
    assert property ($fell(flashWrite) |-> runCnt == 6'h20)
    else $error("burst length");
endmodule : emb_bus_control_checker
bind emb_bus_control emb_bus_control_checker u_chk (.*);

// file: dv/emb_ext_memory.sv
// far-side memory: answers reads with an address pattern, logs writes
// assumes the sixteen-bit multiplexed bus of emb_bus_control
`timescale 1ns/1ps
module emb_ext_memory (
  // clock
  input wire logic ref_clk,
  // bus pins
  input wire logic [19:0] adOut,
  input wire logic addrLatchStrobe,
  input wire logic outputEnable_n,
  input wire logic write_low_strobe_n,
  input wire logic write_high_strobe_n,
  input wire logic lower_byte_enable_n,
  input wire logic upper_byte_enable_n,
  output logic [19:0] adIn
);
  logic [19:0] addrReg = 20'h00000;
  logic [19:0] idlePat = 20'h5A5A5;
  logic [15:0] wrData = 16'h0000;
  logic [3:0] wrFlags = 4'h0; // high, low, upper, lower
  int wrCnt = 0;
  // address caught in the address phase; strobe cycles logged
  always @(posedge ref_clk) begin
    if (addrLatchStrobe) addrReg <= adOut;
    idlePat <= ~idlePat;
    if (!write_low_strobe_n || !write_high_strobe_n) begin
      wrData <= adOut[15:0];
      wrFlags <= {!write_high_strobe_n, !write_low_strobe_n,
        !upper_byte_enable_n, !lower_byte_enable_n};
      wrCnt <= wrCnt + 1;
    end
  end
  // word while read enabled, else a moving pattern
  assign adIn = !outputEnable_n ?
    {4'h0, addrReg[7:0] ^ 8'h5A, addrReg[7:0]} : idlePat;
endmodule : emb_ext_memory

// file: dv/emb_bus_control_tb_top.sv
// self-checking bench for emb_bus_control with a far-side memory
// assumes a sixteen-bit bus strap and a 20 MHz ref_clk
`timescale 1ns/1ps
module emb_bus_control_tb_top;
  import emb_pkg::*;
  logic ref_clk = 1'b0, reset_n = 1'b0, regWrite = 1'b0, regRead = 1'b0;
  logic opStart = 1'b0, opIsWrite = 1'b0, execExternal = 1'b0;
  logic serialProgrammingMode = 1'b0, busWidthFuse = 1'b1;
  logic eraseStart = 1'b0, eraseWholeDevice = 1'b0;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWrData = 8'h00, regRdData;
  emb_ptrop_t opPtrMode = EMB_PTR_KEEP;
  logic [15:0] flashRdData = 16'h1234, flashWrData, fwLast;
  logic [21:0] flashEraseAddr, flashRdAddr, flashWrAddr, fwFirst;
  logic [19:0] adIn, adOut, adOe_n;
  logic opDone, opBusy, flashErase, flashEraseAll, flashRead, flashWrite;
  logic addrLatchStrobe, outputEnable_n, write_low_strobe_n, chipEnable_n;
  logic write_high_strobe_n, byte_address_lsb, lower_byte_enable_n;
  logic upper_byte_enable_n, ctlOe_n, pinsToBus;
  int badCount = 0, checked = 0, fwCnt = 0;
  emb_bus_control uut (.*);
  emb_ext_memory mem (.*);
  always #25 ref_clk = ~ref_clk;
  // array write beats: count, first address, last word
  always @(posedge ref_clk) begin
    if (flashWrite) begin
      if (fwCnt == 0) fwFirst <= flashWrAddr;
      fwLast <= flashWrData;
      fwCnt <= fwCnt + 1;
    end
  end
  task automatic chk(input logic [31:0] g, e, input string s);
    checked++;
    if (g !== e) begin
      badCount++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, s, g, e);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1 chk(regRdData, e, $sformatf("register %0d", a));
  endtask : rd
  task automatic ptr(input logic w, input logic [21:0] p);
    for (int i = 0; i < 3; i++) begin
      if (w) wr(3'(i), 8'(p >> (16 - 8 * i)));
      else rd(3'(i), 8'(p >> (16 - 8 * i)));
    end
  endtask : ptr
  // one table operation; n counts cycles from take to done
  task automatic op(input logic w, input emb_ptrop_t m, output int n);
    @(posedge ref_clk);
    opStart <= 1'b1;
    opIsWrite <= w;
    opPtrMode <= m;
    @(posedge ref_clk);
    opStart <= 1'b0;
    n = 1;
    #1;
    while (opDone !== 1'b1 && n < 40) begin
      @(posedge ref_clk);
      #1 n++;
    end
  endtask : op
  // external write; logged flags and data compared under a mask
  task automatic wt(input logic [7:0] c, d, input logic [21:0] p,
    input logic [19:0] e, k);
    int n, c0;
    wr(3'h4, c);
    wr(3'h3, d);
    ptr(1'b1, p);
    c0 = mem.wrCnt;
    op(1'b1, EMB_PTR_KEEP, n);
    chk({mem.wrFlags, mem.wrData} & k, e, "bus write");
    chk({n[15:0], 16'(mem.wrCnt - c0)},
      c[1] && !p[0] ? 32'h10000 : 32'h50002, "cycles");
  endtask : wt
  task automatic er(input logic w, input logic [1:0] e);
    @(posedge ref_clk);
    eraseStart <= 1'b1;
    eraseWholeDevice <= w;
    @(posedge ref_clk);
    eraseStart <= 1'b0;
    #1 chk({flashErase, flashEraseAll}, e, "erase");
  endtask : er
  task automatic t_regs();
    rd(3'h4, 8'h00);
    rd(3'h3, 8'h00);
    rd(3'h5, 8'h00);
    chk({&adOe_n, write_high_strobe_n, write_low_strobe_n, chipEnable_n,
      outputEnable_n, upper_byte_enable_n, lower_byte_enable_n,
      addrLatchStrobe, byte_address_lsb}, 9'h1FC, "idle pins");
    wr(3'h0, 8'hFF);
    rd(3'h0, 8'h3F);
    wr(3'h1, 8'hA5);
    rd(3'h1, 8'hA5);
    wr(3'h2, 8'h5A);
    rd(3'h2, 8'h5A);
    wr(3'h3, 8'hC3);
    rd(3'h3, 8'hC3);
    wr(3'h4, 8'hFF);
    rd(3'h4, 8'hB3);
    chk(pinsToBus, 1'b0, "pins to io");
    wr(3'h4, 8'h00);
    @(posedge ref_clk);
    #1 chk(pinsToBus, 1'b1, "pins to bus");
    $display("test registers done");
  endtask : t_regs
  task automatic t_ext();
    int n;
    for (int c = 0; c < 4; c++) begin
      wr(3'h4, 8'(c << 4));
      ptr(1'b1, 22'h012344);
      op(1'b0, EMB_PTR_KEEP, n);
      chk(n, 5 + 4 * (3 - c), "wait cycles");
      rd(3'h3, 8'hA2);
    end
    for (int m = 0; m < 4; m++) begin
      ptr(1'b1, m == 2 ? 22'h010001 : 22'h010000);
      op(1'b0, emb_ptrop_t'(m), n);
      ptr(1'b0, m[0] ? 22'h010001 : 22'h010000);
      rd(3'h3, m[1] ? 8'h5A : 8'h00);
    end
    ptr(1'b1, 22'h3FFFFF);
    op(1'b0, EMB_PTR_POSTINC, n);
    ptr(1'b0, 22'h200000);
    op(1'b0, EMB_PTR_POSTDEC, n);
    ptr(1'b0, 22'h3FFFFF);
    $display("test reads done");
  endtask : t_ext
  task automatic t_modes();
    wt(8'h30, 8'h3C, 22'h010010, 20'h43C3C, 20'hFFFFF);
    wt(8'h30, 8'h00, 22'h010011, 20'h80000, 20'hFFFFF);
    wt(8'h31, 8'h5A, 22'h010010, 20'h95A5A, 20'hFFFFF);
    wt(8'h31, 8'hA5, 22'h010011, 20'hAA5A5, 20'hFFFFF);
    wt(8'h32, 8'h11, 22'h010020, 20'hAA5A5, 20'hFFFFF);
    wt(8'h32, 8'h22, 22'h010021, 20'h82211, 20'hCFFFF);
    $display("test write modes done");
  endtask : t_modes
  task automatic t_flash();
    int n;
    wr(3'h4, 8'h30);
    ptr(1'b1, 22'h000101);
    op(1'b0, EMB_PTR_KEEP, n);
    chk(n, 2, "int cycles");
    rd(3'h3, 8'h12);
    ptr(1'b1, 22'h000000);
    op(1'b1, EMB_PTR_KEEP, n);
    er(1'b1, 2'b01);
    repeat (40) @(posedge ref_clk);
    chk(fwCnt, 0, "array");
    serialProgrammingMode <= 1'b1;
    repeat (6) @(posedge ref_clk);
    for (int i = 0; i < 64; i++) begin
      wr(3'h3, 8'(i));
      op(1'b1, EMB_PTR_POSTINC, n);
    end
    repeat (40) @(posedge ref_clk);
    chk(fwCnt, 32, "words");
    chk(fwFirst, 22'h000000, "base");
    chk(fwLast, 16'h3F3E, "last");
    er(1'b0, 2'b10);
    chk(flashEraseAddr, 22'h000040, "erase addr");
    er(1'b1, 2'b11);
    $display("test array done");
  endtask : t_flash
  task automatic conclude();
    $display("checks %0d, mismatches %0d", checked, badCount);
    if (badCount == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  // main sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    t_regs();
    t_ext();
    t_modes();
    t_flash();
    conclude();
  end
  // cuts a hung run short
  initial begin
    repeat (20000) @(posedge ref_clk);
    badCount++;
    conclude();
  end
endmodule : emb_bus_control_tb_top
